// file: verilog/adp_regs.svh
// Register offsets, field positions, reset values and timing counts of the output port.
// Included by the package and the design modules; holds definitions only.
`ifndef ADP_REGS_SVH
`define ADP_REGS_SVH

// Byte addresses on the register bus
`define ADP_CTRL_OFS        8'h00
`define ADP_STATUS_OFS      8'h04
`define ADP_IRQ_STATUS_OFS  8'h08
`define ADP_IRQ_CLEAR_OFS   8'h0C
`define ADP_IRQ_ENABLE_OFS  8'h10
`define ADP_OVR_COUNT_OFS   8'h14

// Control register fields
`define ADP_CTRL_FORCE_STANDBY 0

// Status register fields
`define ADP_STATUS_MODE_LSB    0
`define ADP_STATUS_REF_EXT     2
`define ADP_STATUS_STANDBY     3
`define ADP_STATUS_GAIN_HALF   4

// Interrupt fields, shared by status, clear and enable
`define ADP_IRQ_RANGE          0
`define ADP_IRQ_MODE_CHANGE    1
`define ADP_IRQ_MODE_UNUSED    2
`define ADP_IRQ_WIDTH          3

// Reset values
`define ADP_CTRL_RESET         32'h0000_0000
`define ADP_IRQ_ENABLE_RESET   3'h0

// Timing: sample clock period and pipeline latency in sample clocks
`define ADP_CLK_PERIOD_NS      50
`define ADP_LATENCY_CYCLES     5
`define ADP_CODE_WIDTH         12

`endif

// file: verilog/adp_pkg.sv
// Types shared by the output port modules.
// Assumes adp_regs.svh is on the include path.
`include "adp_regs.svh"
`default_nettype none

package adp_pkg;

  // Configuration pin codes, high pin first
  typedef enum logic [1:0]
  {
    adp_mode_down   = 2'b00,
    adp_mode_x1     = 2'b01,
    adp_mode_half   = 2'b10,
    adp_mode_unused = 2'b11
  } adp_mode_type;

  // Register bus handshake states
  typedef enum logic [0:0]
  {
    adp_bus_idle = 1'b0,
    adp_bus_resp = 1'b1
  } adp_bus_type;

endpackage : adp_pkg

`default_nettype wire

// file: verilog/adp_stage_if.sv
// Carrier between the port controller and its conversion pipeline.
// Assumes both ends run on the same sample clock.
`timescale 1ns/1ps
`default_nettype none

interface adp_stage_if #(parameter int CODE_W = 12);
  logic [CODE_W-1:0] in_code;
  logic              in_ovr;
  logic [CODE_W-1:0] out_code;
  logic              out_ovr;

  modport ctrl (output in_code, output in_ovr, input out_code, input out_ovr);
  modport pipe (input in_code, input in_ovr, output out_code, output out_ovr);
endinterface : adp_stage_if

`default_nettype wire

// file: verilog/adp_pipe.sv
// Conversion pipeline: carries each code and its range flag through DEPTH+1 stages.
// Assumes inputs are stable around the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
`include "adp_regs.svh"

module adp_pipe
  import adp_pkg::*;
#(
  parameter int DEPTH  = `ADP_LATENCY_CYCLES,
  parameter int CODE_W = `ADP_CODE_WIDTH
)
(
  input  wire logic clk,
  input  wire logic rst,
  adp_stage_if.pipe st
);

  logic [CODE_W-1:0] code_q      [DEPTH+1];
  logic [CODE_W-1:0] next_code_q [DEPTH+1];
  logic              ovr_q       [DEPTH+1];
  logic              next_ovr_q  [DEPTH+1];

  ////////////////////////////////////////////////////////////////////////////
  // Stage 0 holds the sample of its own rising edge; DEPTH further edges
  // carry it out, so the code leaves after the fifth following edge.
  // The flag rides with its own code
  genvar g;
  generate
    for (g = 0; g <= DEPTH; g++)
    begin : g_stage
      if (g == 0)
      begin : g_first
        always_comb
        begin
          next_code_q[g] = st.in_code;
          next_ovr_q[g]  = st.in_ovr;
        end
      end
      else
      begin : g_next
        always_comb
        begin
          next_code_q[g] = code_q[g-1];
          next_ovr_q[g]  = ovr_q[g-1];
        end
      end

      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          code_q[g] <= '0;
          ovr_q[g]  <= 1'b0;
        end
        else
        begin
          code_q[g] <= next_code_q[g];
          ovr_q[g]  <= next_ovr_q[g];
        end
      end
    end
  endgenerate

  assign st.out_code = code_q[DEPTH];
  assign st.out_ovr  = ovr_q[DEPTH];

endmodule : adp_pipe

`default_nettype wire

// file: verilog/adp_port.sv
// Digital side of the 12-bit pipelined converter: mode pins, reference select,
// pipeline, tristate output bus, range flag, AXI4-Lite status and interrupts.
// Assumes the converter core presents a code and range bits each rising edge.
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "adp_regs.svh"

module adp_port
  import adp_pkg::*;
#(
  parameter int CODE_W = `ADP_CODE_WIDTH,
  parameter int DEPTH  = `ADP_LATENCY_CYCLES
)
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              cfg_select_high,
  input  wire logic              cfg_select_low,
  input  wire logic              ref_source_select,
  input  wire logic              output_enable_n,
  input  wire logic [CODE_W-1:0] core_code,
  input  wire logic              core_above_upper,
  input  wire logic              core_below_lower,
  output var  logic [CODE_W-1:0] sample_code,
  output logic                   sample_code_oe,
  output var  logic              range_exceeded_pin,
  output var  logic              standby,
  output var  logic              gain_half,
  output var  logic              ref_external,
  output logic                   irq,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [31:0] CTRL_RESET = `ADP_CTRL_RESET;

  adp_stage_if #(.CODE_W(CODE_W)) st ();

  adp_mode_type              mode, next_mode;
  logic                      next_standby, next_gain_half, next_ref_external;
  logic                      force_standby, next_force_standby;
  logic [`ADP_IRQ_WIDTH-1:0] irq_status, next_irq_status;
  logic [`ADP_IRQ_WIDTH-1:0] irq_enable, next_irq_enable;
  logic [15:0]               ovr_count, next_ovr_count;
  logic [CODE_W-1:0]         next_sample_code;
  logic                      next_range;
  logic [`ADP_IRQ_WIDTH-1:0] events;
  adp_bus_type               wst, next_wst, rst_st, next_rst_st;
  logic                      aw_got, next_aw_got, w_got, next_w_got;
  logic [7:0]                waddr, next_waddr;
  logic [31:0]               wdata, next_wdata;
  logic [3:0]                wstrb, next_wstrb;
  logic [1:0]                next_bresp, next_rresp;
  logic                      next_bvalid, next_rvalid;
  logic [31:0]               next_rdata;
  logic                      do_write, aw_now, w_now;
  logic [7:0]                wa;
  logic [31:0]               wd;
  logic [3:0]                ws;

  ////////////////////////////////////////////////////////////////////////////
  // Mode and reference pins; the undefined code idles like standby so the
  // pipeline never carries data of an unknown gain
  always_comb
  begin
    next_mode         = adp_mode_type'({cfg_select_high, cfg_select_low});
    next_standby      = (next_mode == adp_mode_down) || (next_mode == adp_mode_unused)
                        || force_standby;
    next_gain_half    = (next_mode == adp_mode_half);
    next_ref_external = ref_source_select;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mode         <= adp_mode_down;
      standby      <= 1'b1;
      gain_half    <= 1'b0;
      ref_external <= 1'b0;
    end
    else
    begin
      mode         <= next_mode;
      standby      <= next_standby;
      gain_half    <= next_gain_half;
      ref_external <= next_ref_external;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core samples enter the pipeline at the rising edge; standby feeds zeros
  assign st.in_code = standby ? '0 : core_code;
  assign st.in_ovr  = !standby && (core_above_upper || core_below_lower);

  adp_pipe #(.DEPTH(DEPTH), .CODE_W(CODE_W)) u_pipe
  (
    .clk (clk),
    .rst (rst),
    .st  (st.pipe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output register on the falling edge so capture logic can latch at the
  // rising edge with half a period of margin
  always_comb
  begin
    next_sample_code = st.out_code;
    next_range       = st.out_ovr;
  end

  always_ff @(negedge clk)
  begin
    if (rst)
    begin
      sample_code        <= '0;
      range_exceeded_pin <= 1'b0;
    end
    else
    begin
      sample_code        <= next_sample_code;
      range_exceeded_pin <= next_range;
    end
  end

  // Enable pin is not clocked: it may change at any time
  assign sample_code_oe = !output_enable_n;

  ////////////////////////////////////////////////////////////////////////////
  // Events, sticky status and range counter; a set wins over a clear
  assign events[`ADP_IRQ_RANGE]       = st.out_ovr;
  assign events[`ADP_IRQ_MODE_CHANGE] = (next_mode != mode);
  assign events[`ADP_IRQ_MODE_UNUSED] = (next_mode == adp_mode_unused) && (mode != adp_mode_unused);

  always_comb
  begin
    next_irq_status = irq_status;
    next_ovr_count  = ovr_count;
    if (do_write && (wa == `ADP_IRQ_CLEAR_OFS) && ws[0])
      next_irq_status = irq_status & ~wd[`ADP_IRQ_WIDTH-1:0];
    next_irq_status = next_irq_status | events;
    if (st.out_ovr && (ovr_count != 16'hFFFF))
      next_ovr_count = ovr_count + 16'h0001;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq_status <= '0;
      ovr_count  <= 16'h0000;
    end
    else
    begin
      irq_status <= next_irq_status;
      ovr_count  <= next_ovr_count;
    end
  end

  assign irq = |(irq_status & irq_enable);

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order, one response
  assign s_axi_awready = (wst == adp_bus_idle) && !aw_got;
  assign s_axi_wready  = (wst == adp_bus_idle) && !w_got;
  assign aw_now        = s_axi_awvalid && s_axi_awready;
  assign w_now         = s_axi_wvalid && s_axi_wready;
  assign wa            = aw_got ? waddr : s_axi_awaddr;
  assign wd            = w_got ? wdata : s_axi_wdata;
  assign ws            = w_got ? wstrb : s_axi_wstrb;
  assign do_write      = (wst == adp_bus_idle) && (aw_got || aw_now) && (w_got || w_now);

  always_comb
  begin
    next_wst           = wst;
    next_aw_got        = aw_got;
    next_w_got         = w_got;
    next_waddr         = aw_now ? s_axi_awaddr : waddr;
    next_wdata         = w_now ? s_axi_wdata : wdata;
    next_wstrb         = w_now ? s_axi_wstrb : wstrb;
    next_bvalid        = s_axi_bvalid;
    next_bresp         = s_axi_bresp;
    next_force_standby = force_standby;
    next_irq_enable    = irq_enable;
    unique case (wst)
      adp_bus_idle:
      begin
        next_aw_got = aw_got || aw_now;
        next_w_got  = w_got || w_now;
        if (do_write)
        begin
          next_wst    = adp_bus_resp;
          next_aw_got = 1'b0;
          next_w_got  = 1'b0;
          next_bvalid = 1'b1;
          next_bresp  = RESP_OKAY;
          // Read-only registers accept and ignore writes; holes answer with an error
          if (wa == `ADP_CTRL_OFS)
          begin
            if (ws[0])
              next_force_standby = wd[`ADP_CTRL_FORCE_STANDBY];
          end
          else if (wa == `ADP_IRQ_ENABLE_OFS)
          begin
            if (ws[0])
              next_irq_enable = wd[`ADP_IRQ_WIDTH-1:0];
          end
          else if ((wa != `ADP_STATUS_OFS) && (wa != `ADP_IRQ_STATUS_OFS)
                   && (wa != `ADP_IRQ_CLEAR_OFS) && (wa != `ADP_OVR_COUNT_OFS))
            next_bresp = RESP_SLVERR;
        end
      end
      adp_bus_resp:
      begin
        if (s_axi_bready)
        begin
          next_bvalid = 1'b0;
          next_wst    = adp_bus_idle;
        end
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wst           <= adp_bus_idle;
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      waddr         <= 8'h00;
      wdata         <= 32'h0000_0000;
      wstrb         <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      force_standby <= CTRL_RESET[`ADP_CTRL_FORCE_STANDBY];
      irq_enable    <= `ADP_IRQ_ENABLE_RESET;
    end
    else
    begin
      wst           <= next_wst;
      aw_got        <= next_aw_got;
      w_got         <= next_w_got;
      waddr         <= next_waddr;
      wdata         <= next_wdata;
      wstrb         <= next_wstrb;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      force_standby <= next_force_standby;
      irq_enable    <= next_irq_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: data one cycle after the address is taken
  assign s_axi_arready = (rst_st == adp_bus_idle);

  always_comb
  begin
    next_rst_st = rst_st;
    next_rvalid = s_axi_rvalid;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    unique case (rst_st)
      adp_bus_idle:
      begin
        if (s_axi_arvalid)
        begin
          next_rst_st = adp_bus_resp;
          next_rvalid = 1'b1;
          next_rresp  = RESP_OKAY;
          next_rdata  = 32'h0000_0000;
          unique case (s_axi_araddr)
            `ADP_CTRL_OFS:       next_rdata[`ADP_CTRL_FORCE_STANDBY] = force_standby;
            `ADP_STATUS_OFS:
            begin
              next_rdata[`ADP_STATUS_MODE_LSB +: 2] = mode;
              next_rdata[`ADP_STATUS_REF_EXT]       = ref_external;
              next_rdata[`ADP_STATUS_STANDBY]       = standby;
              next_rdata[`ADP_STATUS_GAIN_HALF]     = gain_half;
            end
            `ADP_IRQ_STATUS_OFS: next_rdata[`ADP_IRQ_WIDTH-1:0] = irq_status;
            `ADP_IRQ_CLEAR_OFS:  next_rdata = 32'h0000_0000;
            `ADP_IRQ_ENABLE_OFS: next_rdata[`ADP_IRQ_WIDTH-1:0] = irq_enable;
            `ADP_OVR_COUNT_OFS:  next_rdata[15:0] = ovr_count;
            default:             next_rresp = RESP_SLVERR;
          endcase
        end
      end
      adp_bus_resp:
      begin
        if (s_axi_rready)
        begin
          next_rvalid = 1'b0;
          next_rst_st = adp_bus_idle;
        end
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rst_st       <= adp_bus_idle;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end
    else
    begin
      rst_st       <= next_rst_st;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks: run length of active cycles lets latency checks skip warm-up
  logic [2:0] active_run;
  always_ff @(posedge clk)
  begin
    if (rst || standby)
      active_run <= 3'h0;
    else if (active_run != 3'h7)
      active_run <= active_run + 3'h1;
  end

  property p_latency;
    @(posedge clk) disable iff (rst)
      active_run == 3'h7 |-> sample_code == $past(core_code, 6);
  endproperty
  a_latency: assert property (p_latency) else $error("code latency wrong");

  property p_range_align;
    @(posedge clk) disable iff (rst)
      active_run == 3'h7 |-> range_exceeded_pin == $past(core_above_upper || core_below_lower, 6);
  endproperty
  a_range_align: assert property (p_range_align) else $error("range flag misaligned");

  property p_release;
    @(posedge clk) disable iff (rst)
      output_enable_n |-> !sample_code_oe;
  endproperty
  a_release: assert property (p_release) else $error("bus not released");

  property p_standby;
    @(posedge clk) disable iff (rst)
      (!cfg_select_high && !cfg_select_low) |=> standby && (st.in_code == '0);
  endproperty
  a_standby: assert property (p_standby) else $error("standby not entered");

  property p_gain;
    @(posedge clk) disable iff (rst)
      (cfg_select_high && !cfg_select_low && !force_standby) |=> gain_half && !standby;
  endproperty
  a_gain: assert property (p_gain) else $error("mode decode wrong");

  property p_ref;
    @(posedge clk) disable iff (rst)
      $changed(ref_source_select) |=> ref_external == $past(ref_source_select);
  endproperty
  a_ref: assert property (p_ref) else $error("reference select not followed");

  sequence s_write_taken;
    (wst == adp_bus_idle) && do_write;
  endsequence
  sequence s_write_answer;
    s_axi_bvalid [*1] ##0 (wst == adp_bus_resp);
  endsequence
  property p_write;
    @(posedge clk) disable iff (rst)
      s_write_taken |=> s_write_answer;
  endproperty
  a_write: assert property (p_write) else $error("write not answered");

  property p_read;
    @(posedge clk) disable iff (rst)
      (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_read: assert property (p_read) else $error("read not answered");

  property p_range_sticky;
    @(posedge clk) disable iff (rst)
      st.out_ovr |=> irq_status[`ADP_IRQ_RANGE];
  endproperty
  a_range_sticky: assert property (p_range_sticky) else $error("range event lost");

endmodule : adp_port

`default_nettype wire

// file: sim/adp_capture.sv
// Capture logic standing on the far side of the converter output port.
// Assumes it shares the sample clock and sees the data pins only through the drive enable.
`timescale 1ns/1ps
`default_nettype none

module adp_capture
#(
  parameter int CODE_W = 12
)
(
  input  wire logic              clk,
  input  wire logic [CODE_W-1:0] sample_code,
  input  wire logic              sample_code_oe,
  input  wire logic              range_exceeded_pin,
  output logic      [CODE_W-1:0] bus,
  output logic      [CODE_W-1:0] cap_code,
  output logic                   cap_range
);
  logic [CODE_W-1:0] last;

  ////////////////////////////////////////////////////////////////////////////////
  // Wire level; no pull on the data pins, so a released bus shows the inverse word
  always_comb bus = sample_code_oe ? sample_code : ~last;

  // Latch on the rising edge, half a period clear of the falling-edge update
  always_ff @(posedge clk)
  begin
    if (sample_code_oe)
      last <= sample_code;
    cap_code  <= bus;
    cap_range <= range_exceeded_pin;
  end
endmodule : adp_capture

`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the converter output port: pins, stream, bus and interrupts.
// Assumes the verilog/ files are compiled first and adp_regs.svh is on the include path.
`include "adp_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import adp_pkg::*;
  typedef struct packed {logic [1:0] pins; logic ref_sel; logic sb;} adp_row_type;

  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic [1:0]  pins = 2'h0;
  logic        ref_sel = 1'h0;
  logic        oe_n = 1'h0;
  logic [11:0] core_code = 12'h000;
  logic        above = 1'h0;
  logic        below = 1'h0;
  logic [11:0] sample_code, bus, cap_code;
  logic        sample_code_oe, range_exceeded_pin, standby, gain_half, ref_external;
  logic        irq, cap_range;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  int          errors = 0;
  int          checked = 0;
  logic [11:0] v [32];
  logic        r [32];
  adp_row_type rows [4] = '{'{2'h1, 1'h1, 1'h0}, '{2'h2, 1'h0, 1'h0},
                            '{2'h3, 1'h1, 1'h1}, '{2'h0, 1'h0, 1'h1}};

  ////////////////////////////////////////////////////////////////////////////////
  // 20 MHz sample clock
  always #25 clk = ~clk;

  adp_port u_adp_port (.clk(clk), .rst(rst), .cfg_select_high(pins[1]),
    .cfg_select_low(pins[0]), .ref_source_select(ref_sel), .output_enable_n(oe_n),
    .core_code(core_code), .core_above_upper(above), .core_below_lower(below),
    .sample_code(sample_code), .sample_code_oe(sample_code_oe),
    .range_exceeded_pin(range_exceeded_pin), .standby(standby), .gain_half(gain_half),
    .ref_external(ref_external), .irq(irq), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  adp_capture u_adp_capture (.clk(clk), .sample_code(sample_code),
    .sample_code_oe(sample_code_oe), .range_exceeded_pin(range_exceeded_pin),
    .bus(bus), .cap_code(cap_code), .cap_range(cap_range));

  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude;
    if (errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  // Register write; both halves offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    for (int n = 0; n < 40 && !(bready && bvalid); n++)
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'h0;
      if (wready)
        wvalid <= 1'h0;
    end
    bready <= 1'h0;
    check("bvalid", 32'(bvalid), 32'h1);
    check("bresp", 32'(bresp), 32'(er));
  endtask : axw

  // Register read; only the bits under the mask are compared
  task automatic axr(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask,
                     input logic [1:0] er);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    for (int n = 0; n < 40 && !(rready && rvalid); n++)
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'h0;
    end
    rready <= 1'h0;
    check("rvalid", 32'(rvalid), 32'h1);
    check("rdata", rdata & mask, exp);
    check("rresp", 32'(rresp), 32'(er));
  endtask : axr

  ////////////////////////////////////////////////////////////////////////////////
  // Hang guard: the whole sequence needs well under a thousand cycles
  initial
  begin
    #(50 * 6000);
    errors++;
    conclude();
  end

  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    check("rst standby", 32'(standby), 32'h1);
    check("rst code", 32'(sample_code), 32'h0);
    check("rst irq", 32'(irq), 32'h0);
    rst <= 1'h0;
    axr(`ADP_CTRL_OFS, 32'h0, 32'hFFFFFFFF, 2'h0);
    axr(`ADP_IRQ_ENABLE_OFS, 32'h0, 32'hFFFFFFFF, 2'h0);
    axr(`ADP_IRQ_CLEAR_OFS, 32'h0, 32'hFFFFFFFF, 2'h0);
    axr(8'h20, 32'h0, 32'hFFFFFFFF, 2'h2);
    axw(8'h20, 32'h1, 2'h2);
    axw(`ADP_STATUS_OFS, 32'hFFFFFFFF, 2'h0);
    // Mode pin table, reference select flipped alongside
    foreach (rows[k])
    begin
      pins    <= rows[k].pins;
      ref_sel <= rows[k].ref_sel;
      repeat (3) @(posedge clk);
      check("standby", 32'(standby), 32'(rows[k].sb));
      check("ref_external", 32'(ref_external), 32'(rows[k].ref_sel));
      if (rows[k].pins != 2'h3)
        check("gain_half", 32'(gain_half), 32'(rows[k].pins == 2'h2));
      axr(`ADP_STATUS_OFS, {28'h0, rows[k].sb, rows[k].ref_sel, rows[k].pins}, 32'hF, 2'h0);
    end
    axr(`ADP_IRQ_STATUS_OFS, 32'h6, 32'hFFFFFFFF, 2'h0);
    axw(`ADP_IRQ_ENABLE_OFS, 32'h2, 2'h0);
    @(posedge clk);
    check("irq on", 32'(irq), 32'h1);
    axw(`ADP_IRQ_ENABLE_OFS, 32'h0, 2'h0);
    @(posedge clk);
    check("irq masked", 32'(irq), 32'h0);
    pins <= 2'h1;
    repeat (4) @(posedge clk);
    axw(`ADP_IRQ_CLEAR_OFS, 32'h7, 2'h0);
    axr(`ADP_IRQ_STATUS_OFS, 32'h0, 32'hFFFFFFFF, 2'h0);
    axw(`ADP_IRQ_ENABLE_OFS, 32'h1, 2'h0);
    // Stream: code of edge k due at edge k+6, changing at the falling edge before
    for (int i = 0; i < 32; i++)
    begin
      @(posedge clk);
      if (i >= 7)
      begin
        check("code", 32'(bus), 32'(v[i-7]));
        check("range", 32'(range_exceeded_pin), 32'(r[i-7]));
      end
      if (i >= 8)
      begin
        check("cap code", 32'(cap_code), 32'(v[i-8]));
        check("cap range", 32'(cap_range), 32'(r[i-8]));
      end
      v[i] = (i >= 24 || i % 3 == 1) ? 12'h000 : (i % 3 == 0) ? 12'hFFF : 12'(i * 12'h2D9);
      r[i] = i < 24 && (i % 4 == 1 || i % 4 == 2);
      core_code <= v[i];
      above     <= i < 24 && i % 4 == 1;
      below     <= i < 24 && i % 4 == 2;
      @(negedge clk);
      #1;
      if (i >= 6)
        check("fall", 32'(bus), 32'(v[i-6]));
    end
    check("irq range", 32'(irq), 32'h1);
    axr(`ADP_OVR_COUNT_OFS, 32'hC, 32'hFFFF, 2'h0);
    axw(`ADP_IRQ_CLEAR_OFS, 32'h1, 2'h0);
    @(posedge clk);
    check("irq cleared", 32'(irq), 32'h0);
    // Output enable releases the data pins without waiting for the clock
    oe_n <= 1'h1;
    @(posedge clk);
    #1;
    check("oe off", 32'(sample_code_oe), 32'h0);
    check("released", 32'(bus), {20'h0, ~sample_code});
    @(posedge clk);
    oe_n <= 1'h0;
    #1;
    check("oe on", 32'(sample_code_oe), 32'h1);
    // Forced standby from the control register, then standby from the pins
    core_code <= 12'hABC;
    axw(`ADP_CTRL_OFS, 32'h1, 2'h0);
    repeat (3) @(posedge clk);
    check("forced standby", 32'(standby), 32'h1);
    repeat (8) @(posedge clk);
    check("forced zero", 32'(sample_code), 32'h0);
    axw(`ADP_CTRL_OFS, 32'h0, 2'h0);
    pins      <= 2'h0;
    core_code <= 12'hFFF;
    repeat (10) @(posedge clk);
    check("pin zero", 32'(sample_code), 32'h0);
    conclude();
  end
endmodule : testbench

`default_nettype wire
